// ---- tcx_pkg.sv ----
// Package for the timer and external interrupt control register.
// Assumes one system clock; all users name items as tcx_pkg::name.
`default_nettype none
package tcx_pkg;

  // ----------------------------------------------------------------
  // Register address and reset value
  // ----------------------------------------------------------------
  localparam logic [7:0] TCX_CTRL_ADDR = 8'h88;
  localparam logic [7:0] TCX_CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Bit positions inside the control register
  // ----------------------------------------------------------------
  localparam int unsigned TCX_BIT_T1_OVF = 7;
  localparam int unsigned TCX_BIT_T1_RUN = 6;
  localparam int unsigned TCX_BIT_T0_OVF = 5;
  localparam int unsigned TCX_BIT_T0_RUN = 4;
  localparam int unsigned TCX_BIT_EXT1_FLAG = 3;
  localparam int unsigned TCX_BIT_EXT1_TYPE = 2;
  localparam int unsigned TCX_BIT_EXT0_FLAG = 1;
  localparam int unsigned TCX_BIT_EXT0_TYPE = 0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Vectoring acknowledges or interrupt enables, one bit per source.
  typedef struct packed {
    logic t1;
    logic t0;
    logic ext1;
    logic ext0;
  } tcx_src_t;

  // Configuration held in neighbouring registers of the unit.
  typedef struct packed {
    logic t1_gate;
    logic t0_gate;
    logic ext1_polarity;
    logic ext0_polarity;
    logic t0_split_mode;
  } tcx_cfg_t;

endpackage
`default_nettype wire

// ---- tcx_ext_flag.sv ----
// One external interrupt flag with level or edge detection.
// Assumes the input pin is already synchronous to clock_i.
`default_nettype none
module tcx_ext_flag (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rstn_i,
  // Pin and configuration.
  input wire logic pin_i,
  input wire logic polarity_i,
  input wire logic type_i,
  // Software write and vectoring clear.
  input wire logic we_i,
  input wire logic wv_i,
  input wire logic ack_i,
  // Flag and decoded active level.
  output logic flag_o,
  output logic active_o
);

  logic flag_r;
  logic flag_nxt;
  logic prev_r;
  logic prev_nxt;
  logic edge_seen;

  // Pin is active when it matches the polarity setting.
  assign active_o = (pin_i == polarity_i);
  assign edge_seen = active_o & ~prev_r;
  assign flag_o = flag_r;

  // ----------------------------------------------------------------
  // Next flag value
  // ----------------------------------------------------------------
  // In level mode the flag follows the pin; in edge mode a new edge
  // wins over any clear arriving in the same cycle.
  always_comb begin
    prev_nxt = active_o;
    flag_nxt = flag_r;
    if (!type_i) begin
      flag_nxt = active_o;
    end else if (edge_seen) begin
      flag_nxt = 1'b1;
    end else if (ack_i || (we_i && !wv_i)) begin
      flag_nxt = 1'b0;
    end else if (we_i && wv_i) begin
      flag_nxt = 1'b1;
    end
  end

  // Registers the flag and the previous decoded active level.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      prev_r <= prev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_edge_clear;
    @(posedge clock_i) disable iff (!rstn_i)
      (type_i && ack_i && !edge_seen) |=> !flag_r;
  endproperty
  a_edge_clear: assert property (p_edge_clear)
    else $error("Edge flag not cleared by vectoring.");

  property p_edge_set;
    @(posedge clock_i) disable iff (!rstn_i)
      (type_i && active_o && !prev_r) |=> flag_r;
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("Edge did not set the external flag.");

endmodule
`default_nettype wire

// ---- tcx_ctrl.sv ----
// Timer run and overflow flags plus external interrupt flags and
// types, reached as one byte on the special function register port.
// Assumes all inputs are synchronous to clock_i; the timer datapaths,
// vectoring logic and enable registers sit outside this block.
//
// Notes on behaviour
// - Outside split mode, second timer counts only while its run bit, bit 6, is one.
// - First timer counts only while its run bit, bit 4, is one.
// - Outside split mode, second timer overflow sets bit 7 flag in hardware.
// - Bit 7 flag cleared by software or by vectoring to its routine.
// - First timer overflow sets bit 5 flag in hardware.
// - Bit 5 flag cleared by software or by vectoring to its routine.
// - External 1 flag, bit 3, set on chosen edge or active level.
// - In edge mode external 1 flag clears by software or vectoring.
// - Bit 2 selects external 1 level (0) or edge (1) triggering.
// - External 0 flag, bit 1, set on chosen edge or active level.
// - In edge mode external 0 flag clears by software or vectoring.
// - Bit 0 selects external 0 level (0) or edge (1) triggering.
// - First timer runs when run set and gate off or input active.
// - Split mode: second run bit drives upper byte, its overflow sets bit 7.
`default_nettype none
module tcx_ctrl (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rstn_i,
  // Special function register port.
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_sel_i,
  input wire logic sfr_bit_val_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // Timer overflow events, one-cycle pulses.
  input wire logic t0_ovf_i,
  input wire logic t0_upper_byte_ovf_i,
  input wire logic t1_ovf_i,
  // External interrupt pins.
  input wire logic ext_irq0_input_i,
  input wire logic ext_irq1_input_i,
  // Neighbouring configuration, acknowledges and enables.
  input wire tcx_pkg::tcx_cfg_t cfg_i,
  input wire tcx_pkg::tcx_src_t ack_i,
  input wire tcx_pkg::tcx_src_t irq_en_i,
  // Count enables for the timer datapaths.
  output logic t0_count_en_o,
  output logic t0_upper_byte_en_o,
  output logic t1_count_en_o,
  // Interrupt requests to the core.
  output tcx_pkg::tcx_src_t irq_req_o
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic t1_overflow_flag_r;
  logic t1_overflow_flag_nxt;
  logic t1_run_r;
  logic t1_run_nxt;
  logic t0_overflow_flag_r;
  logic t0_overflow_flag_nxt;
  logic t0_run_r;
  logic t0_run_nxt;
  logic ext_irq1_type_r;
  logic ext_irq1_type_nxt;
  logic ext_irq0_type_r;
  logic ext_irq0_type_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic t0_en_r;
  logic t0_en_nxt;
  logic t0_hi_en_r;
  logic t0_hi_en_nxt;
  logic t1_en_r;
  logic t1_en_nxt;
  tcx_pkg::tcx_src_t irq_r;
  tcx_pkg::tcx_src_t irq_nxt;

  logic ext_irq1_flag;
  logic ext_irq0_flag;
  logic ext0_active;
  logic ext1_active;
  logic hit;
  logic [7:0] wr_en;
  logic [7:0] wr_val;
  logic [7:0] reg_val;
  logic t1_flag_set;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Byte writes touch every bit; bit writes touch only the chosen one.
  assign hit = (sfr_addr_i == tcx_pkg::TCX_CTRL_ADDR);
  always_comb begin
    wr_en = 8'h00;
    wr_val = sfr_wdata_i;
    if (hit && sfr_wr_i) begin
      wr_en = 8'hFF;
    end else if (hit && sfr_bit_wr_i) begin
      wr_en[sfr_bit_sel_i] = 1'b1;
      wr_val = {8{sfr_bit_val_i}};
    end
  end

  // Assembled register image.
  assign reg_val = {t1_overflow_flag_r, t1_run_r, t0_overflow_flag_r,
                    t0_run_r, ext_irq1_flag, ext_irq1_type_r,
                    ext_irq0_flag, ext_irq0_type_r};

  // In split mode the upper byte of timer 0 owns the bit 7 flag.
  assign t1_flag_set = cfg_i.t0_split_mode ? t0_upper_byte_ovf_i
                                           : t1_ovf_i;

  // ----------------------------------------------------------------
  // External interrupt flags
  // ----------------------------------------------------------------
  tcx_ext_flag u_ext0 (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .pin_i(ext_irq0_input_i),
    .polarity_i(cfg_i.ext0_polarity),
    .type_i(ext_irq0_type_r),
    .we_i(wr_en[tcx_pkg::TCX_BIT_EXT0_FLAG]),
    .wv_i(wr_val[tcx_pkg::TCX_BIT_EXT0_FLAG]),
    .ack_i(ack_i.ext0),
    .flag_o(ext_irq0_flag),
    .active_o(ext0_active)
  );

  tcx_ext_flag u_ext1 (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .pin_i(ext_irq1_input_i),
    .polarity_i(cfg_i.ext1_polarity),
    .type_i(ext_irq1_type_r),
    .we_i(wr_en[tcx_pkg::TCX_BIT_EXT1_FLAG]),
    .wv_i(wr_val[tcx_pkg::TCX_BIT_EXT1_FLAG]),
    .ack_i(ack_i.ext1),
    .flag_o(ext_irq1_flag),
    .active_o(ext1_active)
  );

  // ----------------------------------------------------------------
  // Next values of control bits, flags and outputs
  // ----------------------------------------------------------------
  // Hardware sets win over software or vectoring clears.
  always_comb begin
    t1_run_nxt = wr_en[tcx_pkg::TCX_BIT_T1_RUN] ?
                 wr_val[tcx_pkg::TCX_BIT_T1_RUN] : t1_run_r;
    t0_run_nxt = wr_en[tcx_pkg::TCX_BIT_T0_RUN] ?
                 wr_val[tcx_pkg::TCX_BIT_T0_RUN] : t0_run_r;
    ext_irq1_type_nxt = wr_en[tcx_pkg::TCX_BIT_EXT1_TYPE] ?
                 wr_val[tcx_pkg::TCX_BIT_EXT1_TYPE] : ext_irq1_type_r;
    ext_irq0_type_nxt = wr_en[tcx_pkg::TCX_BIT_EXT0_TYPE] ?
                 wr_val[tcx_pkg::TCX_BIT_EXT0_TYPE] : ext_irq0_type_r;
    t1_overflow_flag_nxt = t1_overflow_flag_r;
    if (t1_flag_set) begin
      t1_overflow_flag_nxt = 1'b1;
    end else if (ack_i.t1) begin
      t1_overflow_flag_nxt = 1'b0;
    end else if (wr_en[tcx_pkg::TCX_BIT_T1_OVF]) begin
      t1_overflow_flag_nxt = wr_val[tcx_pkg::TCX_BIT_T1_OVF];
    end
    t0_overflow_flag_nxt = t0_overflow_flag_r;
    if (t0_ovf_i) begin
      t0_overflow_flag_nxt = 1'b1;
    end else if (ack_i.t0) begin
      t0_overflow_flag_nxt = 1'b0;
    end else if (wr_en[tcx_pkg::TCX_BIT_T0_OVF]) begin
      t0_overflow_flag_nxt = wr_val[tcx_pkg::TCX_BIT_T0_OVF];
    end
    t0_en_nxt = t0_run_r & (~cfg_i.t0_gate | ext0_active);
    t0_hi_en_nxt = cfg_i.t0_split_mode & t1_run_r;
    // In split mode timer 1 run control passes to its mode settings.
    t1_en_nxt = cfg_i.t0_split_mode |
                (t1_run_r & (~cfg_i.t1_gate | ext1_active));
    irq_nxt.t1 = t1_overflow_flag_r & irq_en_i.t1;
    irq_nxt.t0 = t0_overflow_flag_r & irq_en_i.t0;
    irq_nxt.ext1 = ext_irq1_flag & irq_en_i.ext1;
    irq_nxt.ext0 = ext_irq0_flag & irq_en_i.ext0;
    rdata_nxt = (hit && sfr_rd_i) ? reg_val : 8'h00;
  end

  // Registers all state; reset gives the documented all-zero image.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      t1_overflow_flag_r <= tcx_pkg::TCX_CTRL_RESET[7];
      t1_run_r <= tcx_pkg::TCX_CTRL_RESET[6];
      t0_overflow_flag_r <= tcx_pkg::TCX_CTRL_RESET[5];
      t0_run_r <= tcx_pkg::TCX_CTRL_RESET[4];
      ext_irq1_type_r <= tcx_pkg::TCX_CTRL_RESET[2];
      ext_irq0_type_r <= tcx_pkg::TCX_CTRL_RESET[0];
      rdata_r <= 8'h00;
      t0_en_r <= 1'b0;
      t0_hi_en_r <= 1'b0;
      t1_en_r <= 1'b0;
      irq_r <= '0;
    end else begin
      t1_overflow_flag_r <= t1_overflow_flag_nxt;
      t1_run_r <= t1_run_nxt;
      t0_overflow_flag_r <= t0_overflow_flag_nxt;
      t0_run_r <= t0_run_nxt;
      ext_irq1_type_r <= ext_irq1_type_nxt;
      ext_irq0_type_r <= ext_irq0_type_nxt;
      rdata_r <= rdata_nxt;
      t0_en_r <= t0_en_nxt;
      t0_hi_en_r <= t0_hi_en_nxt;
      t1_en_r <= t1_en_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign sfr_rdata_o = rdata_r;
  assign t0_count_en_o = t0_en_r;
  assign t0_upper_byte_en_o = t0_hi_en_r;
  assign t1_count_en_o = t1_en_r;
  assign irq_req_o = irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_t1_stop;
    @(posedge clock_i) disable iff (!rstn_i)
      (!t1_run_r && !cfg_i.t0_split_mode) |=> !t1_count_en_o;
  endproperty
  a_t1_stop: assert property (p_t1_stop)
    else $error("Second timer counts with run bit low.");

  property p_t0_stop;
    @(posedge clock_i) disable iff (!rstn_i)
      !t0_run_r |=> !t0_count_en_o;
  endproperty
  a_t0_stop: assert property (p_t0_stop)
    else $error("First timer counts with run bit low.");

  property p_t1_set;
    @(posedge clock_i) disable iff (!rstn_i)
      (t1_ovf_i && !cfg_i.t0_split_mode) |=> reg_val[7];
  endproperty
  a_t1_set: assert property (p_t1_set)
    else $error("Second timer overflow flag not set.");

  property p_t1_ack;
    @(posedge clock_i) disable iff (!rstn_i)
      (ack_i.t1 && !t1_flag_set) |=> !t1_overflow_flag_r;
  endproperty
  a_t1_ack: assert property (p_t1_ack)
    else $error("Second timer flag not cleared by vectoring.");

  property p_t0_set;
    @(posedge clock_i) disable iff (!rstn_i)
      t0_ovf_i |=> reg_val[5] ##1 (reg_val[5] || $past(ack_i.t0)
                                   || $past(wr_en[5]));
  endproperty
  a_t0_set: assert property (p_t0_set)
    else $error("First timer overflow flag not set or lost.");

  property p_t0_ack;
    @(posedge clock_i) disable iff (!rstn_i)
      (ack_i.t0 && !t0_ovf_i) |=> !reg_val[5];
  endproperty
  a_t0_ack: assert property (p_t0_ack)
    else $error("First timer flag not cleared by vectoring.");

  property p_ext1_level;
    @(posedge clock_i) disable iff (!rstn_i)
      (!ext_irq1_type_r) |=> (reg_val[3] == $past(ext1_active));
  endproperty
  a_ext1_level: assert property (p_ext1_level)
    else $error("External 1 level flag does not follow pin.");

  property p_ext0_level;
    @(posedge clock_i) disable iff (!rstn_i)
      (!ext_irq0_type_r) |=> (reg_val[1] == $past(ext0_active));
  endproperty
  a_ext0_level: assert property (p_ext0_level)
    else $error("External 0 level flag does not follow pin.");

  property p_gate;
    @(posedge clock_i) disable iff (!rstn_i)
      (t0_run_r && cfg_i.t0_gate) |=> (t0_count_en_o == $past(ext0_active));
  endproperty
  a_gate: assert property (p_gate)
    else $error("Gated first timer ignores the external input.");

  property p_split;
    @(posedge clock_i) disable iff (!rstn_i)
      (cfg_i.t0_split_mode && t0_upper_byte_ovf_i) |=> t1_overflow_flag_r
      ##0 (t0_upper_byte_en_o == $past(t1_run_r));
  endproperty
  a_split: assert property (p_split)
    else $error("Split mode upper byte not tied to second timer bits.");

  property p_irq;
    @(posedge clock_i) disable iff (!rstn_i)
      (t0_overflow_flag_r && irq_en_i.t0) |=> irq_req_o.t0;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt request missing for set enabled flag.");

endmodule
`default_nettype wire

// ---- tcx_core_model.sv ----
// Behavioural model of the core's interrupt vectoring logic.
// Assumes the registered request levels of tcx_ctrl on one clock.
`default_nettype none
module tcx_core_model (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rstn_i,
  // Requests and vectoring control.
  input wire tcx_pkg::tcx_src_t irq_req_i,
  input wire logic vec_en_i,
  input wire logic [3:0] delay_i,
  // Acknowledge pulse back to the register.
  output var tcx_pkg::tcx_src_t ack_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Vectoring
  // ----------------------------------------------------------------
  // Picks the pending source with the highest fixed priority.
  function automatic tcx_pkg::tcx_src_t pick(input tcx_pkg::tcx_src_t r);
    pick = 4'h0;
    if (r.ext0) pick.ext0 = 1'b1;
    else if (r.t0) pick.t0 = 1'b1;
    else if (r.ext1) pick.ext1 = 1'b1;
    else pick.t1 = r.t1;
  endfunction

  // Acknowledges one pending request after a chosen latency, then
  // waits so the dropping request is not taken a second time.
  initial begin
    ack_o = 4'h0;
    forever begin
      @(negedge clock_i);
      if (rstn_i && vec_en_i && irq_req_i != 4'h0) begin
        repeat (delay_i) @(negedge clock_i);
        ack_o = pick(irq_req_i);
        @(negedge clock_i);
        ack_o = 4'h0;
        repeat (3) @(negedge clock_i);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tcx_ctrl_tb.sv ----
// Self-checking testbench for the timer and interrupt control byte.
// Assumes tcx_ctrl and tcx_core_model; inputs change on falling edges.
`default_nettype none
module tcx_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clock_i, rstn_i, wr, bit_wr, bit_val, rd, vec_en;
  logic t0_ovf, t0u_ovf, t1_ovf, pin0, pin1, t0_en, t0u_en, t1_en;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] bit_sel;
  logic [3:0] vec_dly;
  tcx_pkg::tcx_cfg_t cfg;
  tcx_pkg::tcx_src_t ack, irq_en, irq_req;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  tcx_ctrl tcx_ctrl_inst (.clock_i(clock_i), .rstn_i(rstn_i),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
    .sfr_bit_wr_i(bit_wr), .sfr_bit_sel_i(bit_sel),
    .sfr_bit_val_i(bit_val), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
    .t0_ovf_i(t0_ovf), .t0_upper_byte_ovf_i(t0u_ovf), .t1_ovf_i(t1_ovf),
    .ext_irq0_input_i(pin0), .ext_irq1_input_i(pin1), .cfg_i(cfg),
    .ack_i(ack), .irq_en_i(irq_en), .t0_count_en_o(t0_en),
    .t0_upper_byte_en_o(t0u_en), .t1_count_en_o(t1_en),
    .irq_req_o(irq_req));

  tcx_core_model tcx_core_model_inst (.clock_i(clock_i),
    .rstn_i(rstn_i), .irq_req_i(irq_req), .vec_en_i(vec_en),
    .delay_i(vec_dly), .ack_o(ack));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Byte write, then single-bit write, each one strobe cycle long.
  task automatic wr_byte(input logic [7:0] d);
    @(negedge clock_i);
    addr = tcx_pkg::TCX_CTRL_ADDR;
    wdata = d;
    wr = 1'b1;
    @(negedge clock_i);
    wr = 1'b0;
  endtask

  task automatic wr_bit(input logic [2:0] s, input logic v);
    @(negedge clock_i);
    addr = tcx_pkg::TCX_CTRL_ADDR;
    bit_sel = s;
    bit_val = v;
    bit_wr = 1'b1;
    @(negedge clock_i);
    bit_wr = 1'b0;
  endtask

  // Reads one byte; the data stands in the cycle after the strobe.
  task automatic rd_chk(input string what, input logic [7:0] exp,
                        input logic [7:0] a = tcx_pkg::TCX_CTRL_ADDR);
    @(negedge clock_i);
    addr = a;
    rd = 1'b1;
    @(negedge clock_i);
    rd = 1'b0;
    check(what, rdata, exp);
  endtask

  // One-cycle overflow pulse: 0 first timer, 1 upper byte, 2 second.
  task automatic pulse(input int idx);
    @(negedge clock_i);
    {t1_ovf, t0u_ovf, t0_ovf} = 3'h1 << idx;
    @(negedge clock_i);
    {t1_ovf, t0u_ovf, t0_ovf} = 3'h0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Waits a bounded time for one request bit to drop.
  task automatic wait_clear(input string what, input int idx);
    for (int k = 0; k < 20 && irq_req[idx] !== 1'b0; k++) tick(1);
    check(what, {7'h00, irq_req[idx]}, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, timeout and tests
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {rstn_i, wr, bit_wr, bit_val, rd, vec_en} = 6'h00;
    {t0_ovf, t0u_ovf, t1_ovf, pin0, pin1} = 5'h00;
    {addr, wdata, bit_sel, vec_dly, irq_en} = 27'h0;
    cfg = 5'h06; // Both pins active high.
    tick(8);
    rstn_i = 1'b1;
    rd_chk("reset", tcx_pkg::TCX_CTRL_RESET);
    $display("test reset done");
    wr_byte(8'h50);
    rd_chk("runs", 8'h50);
    rd_chk("unmapped", 8'h00, 8'h89);
    check("t0_en", {7'h00, t0_en}, 8'h01);
    check("t1_en", {7'h00, t1_en}, 8'h01);
    check("t0u_en", {7'h00, t0u_en}, 8'h00);
    cfg.t0_gate = 1'b1;
    tick(2);
    check("gated", {7'h00, t0_en}, 8'h00);
    pin0 = 1'b1;
    tick(2);
    check("gate open", {7'h00, t0_en}, 8'h01);
    pin0 = 1'b0;
    cfg.t0_gate = 1'b0;
    wr_byte(8'h00);
    tick(2);
    check("t0 stop", {7'h00, t0_en}, 8'h00);
    check("t1 stop", {7'h00, t1_en}, 8'h00);
    $display("test run done");
    irq_en = 4'hF;
    pulse(0);
    tick(1);
    check("irq t0", {7'h00, irq_req.t0}, 8'h01);
    rd_chk("t0 ovf", 8'h20);
    vec_dly = 4'h2;
    vec_en = 1'b1;
    wait_clear("irq t0 vec", 2);
    vec_en = 1'b0;
    rd_chk("t0 vec", 8'h00);
    pulse(2);
    tick(1);
    check("irq t1", {7'h00, irq_req.t1}, 8'h01);
    rd_chk("t1 ovf", 8'h80);
    wr_bit(3'h7, 1'b0);
    rd_chk("t1 sw clr", 8'h00);
    $display("test overflow done");
    cfg.t0_split_mode = 1'b1;
    wr_bit(3'h6, 1'b1);
    tick(2);
    check("upper en", {7'h00, t0u_en}, 8'h01);
    pulse(2);
    rd_chk("split t1", 8'h40);
    pulse(1);
    rd_chk("split ovf", 8'hC0);
    wr_byte(8'h00);
    cfg.t0_split_mode = 1'b0;
    $display("test split done");
    wr_byte(8'h05);
    pin1 = 1'b1;
    tick(2);
    rd_chk("edge1", 8'h0D);
    check("irq e1", {7'h00, irq_req.ext1}, 8'h01);
    wr_bit(3'h3, 1'b0);
    rd_chk("edge1 clr", 8'h05);
    pin1 = 1'b0;
    vec_dly = 4'h6;
    vec_en = 1'b1;
    pin0 = 1'b1;
    tick(3);
    check("irq e0", {7'h00, irq_req.ext0}, 8'h01);
    wait_clear("irq e0 vec", 0);
    vec_en = 1'b0;
    rd_chk("edge0 vec", 8'h05);
    pin0 = 1'b0;
    $display("test edge done");
    wr_byte(8'h00);
    {pin0, pin1} = 2'h3;
    tick(2);
    rd_chk("level", 8'h0A);
    wr_byte(8'h00);
    rd_chk("level hold", 8'h0A);
    {pin0, pin1} = 2'h0;
    tick(2);
    rd_chk("level off", 8'h00);
    $display("test level done");
    // Vectoring clear of the second timer flag, alone in the queue.
    pulse(2);
    tick(1);
    check("irq t1 again", {7'h00, irq_req.t1}, 8'h01);
    vec_dly = 4'h1;
    vec_en = 1'b1;
    wait_clear("irq t1 vec", 3);
    vec_en = 1'b0;
    rd_chk("t1 vec", 8'h00);
    // Software clear of the first timer flag, then set against clear.
    pulse(0);
    wr_bit(3'h5, 1'b0);
    rd_chk("t0 sw clr", 8'h00);
    @(negedge clock_i);
    addr = tcx_pkg::TCX_CTRL_ADDR;
    bit_sel = 3'h5;
    bit_val = 1'b0;
    bit_wr = 1'b1;
    t0_ovf = 1'b1;
    @(negedge clock_i);
    bit_wr = 1'b0;
    t0_ovf = 1'b0;
    rd_chk("t0 set wins", 8'h20);
    wr_bit(3'h5, 1'b0);
    // Vectoring clear of external 1 in edge mode.
    wr_byte(8'h05);
    pin1 = 1'b1;
    tick(2);
    check("irq e1 again", {7'h00, irq_req.ext1}, 8'h01);
    vec_dly = 4'h1;
    vec_en = 1'b1;
    wait_clear("irq e1 vec", 1);
    vec_en = 1'b0;
    rd_chk("edge1 vec", 8'h05);
    pin1 = 1'b0;
    // Active low external 0 pin, edge mode, software clear.
    pin0 = 1'b1;
    cfg.ext0_polarity = 1'b0;
    tick(2);
    pin0 = 1'b0;
    tick(2);
    rd_chk("edge0 low", 8'h07);
    wr_bit(3'h1, 1'b0);
    rd_chk("edge0 sw clr", 8'h05);
    cfg.ext0_polarity = 1'b1;
    $display("test clear done");
    // Second timer gated by the external 1 pin.
    wr_byte(8'h40);
    cfg.t1_gate = 1'b1;
    tick(2);
    check("t1 gated", {7'h00, t1_en}, 8'h00);
    pin1 = 1'b1;
    tick(2);
    check("t1 gate open", {7'h00, t1_en}, 8'h01);
    pin1 = 1'b0;
    cfg.t1_gate = 1'b0;
    $display("test gate done");
    // Reset in mid-run returns every output and bit to zero.
    wr_byte(8'hF5);
    tick(2);
    check("pre rst irq", {4'h0, irq_req}, 8'h0C);
    rstn_i = 1'b0;
    tick(2);
    check("rst irq", {4'h0, irq_req}, 8'h00);
    check("rst enables", {5'h00, t0_en, t0u_en, t1_en}, 8'h00);
    rstn_i = 1'b1;
    rd_chk("reset again", tcx_pkg::TCX_CTRL_RESET);
    check("rst rel irq", {4'h0, irq_req}, 8'h00);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
